// >>> hdl/idt_decoder.sv
// instruction decode and cycle timing with an AXI4-Lite register port
// Functional notes
// - two-word instructions form one 48-bit operation beside single-word ones
// - second word of a two-word instruction has its top eight bits zero
// - a lone second word executes as a no-operation
// - every two-word instruction takes exactly two cycles
// - single-word ops take one cycle, two when condition true or flow changes, three for returns
// - branch, indirect jump, table access and returns take two or three cycles
// - a taken skip costs two cycles, three over a two-word instruction
// - two-word data moves take two cycles
// - file address operand spans 0 up to 0x1FFF
// - bit select is 4 bits, base register picks one of sixteen
// - accumulator write-back goes to W13 or to [W13] with post-increment 2
// - accumulator operand selects A or B only
// - ten-bit signed literal is two's complement, -512 to 511
// - carry, digit carry, negative, overflow and sticky zero flags are kept
// - DSP flags keep overflow and saturation of accumulators A and B
// - size modifier picks byte, word or double, word default; shadow select
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module idt_decoder (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_ce,
  input  wire logic                     i_awvalid,
  output logic                          o_awready,
  input  wire logic [7:0]               i_awaddr,
  input  wire logic                     i_wvalid,
  output logic                          o_wready,
  input  wire logic [31:0]              i_wdata,
  input  wire logic [3:0]               i_wstrb,
  output logic                          o_bvalid,
  input  wire logic                     i_bready,
  output logic [1:0]                    o_bresp,
  input  wire logic                     i_arvalid,
  output logic                          o_arready,
  input  wire logic [7:0]               i_araddr,
  output logic                          o_rvalid,
  input  wire logic                     i_rready,
  output logic [31:0]                   o_rdata,
  output logic [1:0]                    o_rresp,
  input  wire logic                     i_fetch_valid,
  input  wire logic [idt_pkg::WORD_W-1:0] i_fetch_word,
  output logic                          o_fetch_ready,
  input  wire logic                     i_cond_true,
  input  wire logic [idt_pkg::FLAG_W-1:0] i_flag_we,
  input  wire logic [idt_pkg::FLAG_W-1:0] i_flag_val,
  output logic                          o_op_valid,
  output idt_pkg::idt_class_e           o_op_class,
  output logic [idt_pkg::WORD_W-1:0]    o_op_word1,
  output logic [idt_pkg::WORD_W-1:0]    o_op_word2,
  output logic [1:0]                    o_op_cycles,
  output logic                          o_nop_cycle,
  output logic [22:0]                   o_wide_program_literal,
  output logic                          o_literal_fault,
  output logic [15:0]                   o_signed_ten_bit_literal,
  output logic [3:0]                    o_bit_select_operand,
  output logic [3:0]                    o_base_work_register,
  output logic                          o_acc_b_sel,
  output logic                          o_accumulator_writeback_target,
  output logic [1:0]                    o_op_size,
  output logic                          o_shadow_sel,
  output logic [12:0]                   o_file_addr,
  output logic [idt_pkg::FLAG_W-1:0]    o_flags
);
  import idt_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_WAIT2, ST_SKIP1, ST_SKIP2} idt_state_e;

  // ---------------------------------------------------------------
  // decode sequencer state
  // ---------------------------------------------------------------
  idt_state_e          st_reg, st_next;
  logic                opv_reg, opv_next;
  idt_class_e          cls_reg, cls_next;
  logic [WORD_W-1:0]   w1_reg, w1_next;
  logic [WORD_W-1:0]   w2_reg, w2_next;
  logic [1:0]          cyc_reg, cyc_next;
  logic                nopc_reg, nopc_next;
  logic [ERR_W-1:0]    err_set;
  idt_class_e          in_cls;
  logic                take;
  logic                ctrl_reg;

  idt_nop_if nop ();

  idt_nop_timer u_timer (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_ce  (i_ce),
    .nop   (nop)
  );

  // stall while extra cycles run or software has decoding switched off
  assign o_fetch_ready = ctrl_reg & ~nop.busy;
  assign take          = i_ce & i_fetch_valid & o_fetch_ready;
  assign in_cls        = idt_class_of(i_fetch_word);

  always_comb begin
    st_next   = st_reg;
    opv_next  = 1'b0;
    cls_next  = cls_reg;
    w1_next   = w1_reg;
    w2_next   = w2_reg;
    cyc_next  = cyc_reg;
    nopc_next = nop.busy;
    err_set   = '0;
    nop.load  = 1'b0;
    nop.count = NOP_NONE;
    if (take) begin
      case (st_reg)
        ST_RUN: begin
          w1_next = i_fetch_word;
          w2_next = '0;
          if (idt_is_double(i_fetch_word)) begin
            st_next = ST_WAIT2;
          end else begin
            // opcode byte zero, as on a stray second word, is a no-operation
            opv_next = 1'b1;
            cls_next = in_cls;
            cyc_next = CYC_ONE;
            case (in_cls)
              CL_BRANCH, CL_IND_JUMP, CL_TBL_RD, CL_TBL_WR: begin
                cyc_next  = CYC_TWO;
                nop.load  = 1'b1;
                nop.count = NOP_ONE;
              end
              CL_RET, CL_IRET: begin
                cyc_next  = CYC_THREE;
                nop.load  = 1'b1;
                nop.count = NOP_TWO;
              end
              CL_CBRANCH: begin
                if (i_cond_true) begin
                  cyc_next  = CYC_TWO;
                  nop.load  = 1'b1;
                  nop.count = NOP_ONE;
                end
              end
              CL_SKIP: begin
                if (i_cond_true) begin
                  st_next = ST_SKIP1;
                end
              end
              default: begin
                cyc_next = CYC_ONE;
              end
            endcase
          end
        end
        ST_WAIT2: begin
          // second word completes the held op, never decoded on its own
          opv_next = 1'b1;
          cls_next = idt_class_of(w1_reg);
          w2_next  = i_fetch_word;
          cyc_next = CYC_TWO;
          err_set[ER_W2]  = (i_fetch_word[23:16] != OPC_NOP);
          err_set[ER_LIT] = (idt_class_of(w1_reg) != CL_MOVD_DW) & w1_reg[0];
          st_next  = ST_RUN;
        end
        ST_SKIP1: begin
          // skipped word is dropped; a two-word one costs one more slot
          nopc_next = 1'b1;
          st_next   = idt_is_double(i_fetch_word) ? ST_SKIP2 : ST_RUN;
        end
        ST_SKIP2: begin
          nopc_next = 1'b1;
          st_next   = ST_RUN;
        end
        default: begin
          st_next = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg   <= ST_RUN;
      opv_reg  <= 1'b0;
      cls_reg  <= CL_NOP;
      w1_reg   <= '0;
      w2_reg   <= '0;
      cyc_reg  <= CYC_ONE;
      nopc_reg <= 1'b0;
    end else if (i_ce) begin
      st_reg   <= st_next;
      opv_reg  <= opv_next;
      cls_reg  <= cls_next;
      w1_reg   <= w1_next;
      w2_reg   <= w2_next;
      cyc_reg  <= cyc_next;
      nopc_reg <= nopc_next;
    end
  end

  // ---------------------------------------------------------------
  // operand views of the issued op
  // ---------------------------------------------------------------
  assign o_op_valid   = opv_reg;
  assign o_op_class   = cls_reg;
  assign o_op_word1   = w1_reg;
  assign o_op_word2   = w2_reg;
  assign o_op_cycles  = cyc_reg;
  assign o_nop_cycle  = nopc_reg;
  assign o_wide_program_literal   = {w2_reg[6:0], w1_reg[15:0]};
  assign o_literal_fault          = w1_reg[0] & ((cls_reg == CL_GOTO_DW) |
                                    (cls_reg == CL_CALL_DW));
  assign o_signed_ten_bit_literal = {{6{w1_reg[9]}}, w1_reg[9:0]};
  assign o_bit_select_operand     = w1_reg[3:0];
  assign o_base_work_register     = w1_reg[10:7];
  assign o_acc_b_sel              = w1_reg[12];
  // low selects W13 itself, high selects [W13] then W13 += 2
  assign o_accumulator_writeback_target = w1_reg[11];
  // code 3 is unused and falls back to word size
  assign o_op_size    = (w1_reg[15:14] == 2'h3) ? SZ_WORD : w1_reg[15:14];
  assign o_shadow_sel = w1_reg[13];
  assign o_file_addr  = w1_reg[12:0];

  // ---------------------------------------------------------------
  // status flags, error sticky bits and counters
  // ---------------------------------------------------------------
  logic [FLAG_W-1:0] flags_reg, flags_next;
  logic [ERR_W-1:0]  err_reg, err_next;
  logic [31:0]       count_reg, count_next;
  logic              ctrl_next;
  logic              wr_fire;
  logic [7:0]        aw_addr_reg;
  logic [31:0]       w_data_reg;

  always_comb begin
    flags_next = flags_reg;
    err_next   = err_reg;
    ctrl_next  = ctrl_reg;
    count_next = count_reg + {31'h0, opv_next};
    if (wr_fire && aw_addr_reg == REG_CTRL) begin
      ctrl_next = w_data_reg[0];
    end
    if (wr_fire && aw_addr_reg == REG_FLAGS) begin
      flags_next = w_data_reg[FLAG_W-1:0];
    end
    if (wr_fire && aw_addr_reg == REG_ERR) begin
      err_next = err_reg & ~w_data_reg[ERR_W-1:0];
    end
    err_next = err_next | err_set;
    for (int i = 0; i < FLAG_W; i++) begin
      if (i_flag_we[i]) begin
        // zero flag is sticky: a zero result never sets it, nonzero clears it
        flags_next[i] = (i == FL_Z) ? (flags_reg[i] & i_flag_val[i])
                                    : i_flag_val[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flags_reg <= FLAGS_RST;
      err_reg   <= ERR_RST;
      ctrl_reg  <= CTRL_RST;
      count_reg <= 32'h0;
    end else if (i_ce) begin
      flags_reg <= flags_next;
      err_reg   <= err_next;
      ctrl_reg  <= ctrl_next;
      count_reg <= count_next;
    end
  end

  assign o_flags = flags_reg;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic        aw_have_reg, aw_have_next;
  logic        w_have_reg, w_have_next;
  logic [7:0]  aw_addr_next;
  logic [31:0] w_data_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;

  function automatic logic idt_mapped(input logic [7:0] a);
    return (a == REG_CTRL) || (a == REG_FLAGS) || (a == REG_LAST) ||
           (a == REG_COUNT) || (a == REG_ERR);
  endfunction

  assign o_awready = ~aw_have_reg & ~bvalid_reg;
  assign o_wready  = ~w_have_reg & ~bvalid_reg;
  assign o_arready = ~rvalid_reg;
  assign wr_fire   = aw_have_reg & w_have_reg & ~bvalid_reg & (i_wstrb != 4'h0);

  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next  = w_have_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next  = w_data_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (i_awvalid && o_awready) begin
      aw_have_next = 1'b1;
      aw_addr_next = {i_awaddr[7:2], 2'b00};
    end
    if (i_wvalid && o_wready) begin
      w_have_next = 1'b1;
      w_data_next = i_wdata;
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = idt_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && i_bready) begin
      bvalid_next = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = idt_mapped({i_araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
      case ({i_araddr[7:2], 2'b00})
        REG_CTRL:  rdata_next = {31'h0, ctrl_reg};
        REG_FLAGS: rdata_next = {23'h0, flags_reg};
        REG_LAST:  rdata_next = {24'h0, cyc_reg, 1'b0, opv_reg, cls_reg};
        REG_COUNT: rdata_next = count_reg;
        REG_ERR:   rdata_next = {30'h0, err_reg};
        default:   rdata_next = 32'h0;
      endcase
    end else if (rvalid_reg && i_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= RESP_OKAY;
    end else if (i_ce) begin
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg  <= w_data_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign o_bvalid = bvalid_reg;
  assign o_bresp  = bresp_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata  = rdata_reg;
  assign o_rresp  = rresp_reg;
endmodule
`default_nettype wire

// >>> hdl/idt_pkg.sv
// constants, types and decode helpers for the instruction decode and timing block
package idt_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W   = 24;
  localparam int unsigned FLAG_W   = 9;
  localparam int unsigned ERR_W    = 2;
  localparam int unsigned CNT_W    = 2;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h04;
  localparam logic [7:0] REG_LAST  = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0C;
  localparam logic [7:0] REG_ERR   = 8'h10;

  localparam logic        CTRL_RST  = 1'b1;
  localparam logic [8:0]  FLAGS_RST = 9'h000;
  localparam logic [1:0]  ERR_RST   = 2'h0;

  // flag positions
  localparam int unsigned FL_C  = 0;
  localparam int unsigned FL_DC = 1;
  localparam int unsigned FL_N  = 2;
  localparam int unsigned FL_OV = 3;
  localparam int unsigned FL_Z  = 4;
  localparam int unsigned FL_OA = 5;
  localparam int unsigned FL_OB = 6;
  localparam int unsigned FL_SA = 7;
  localparam int unsigned FL_SB = 8;

  // error positions
  localparam int unsigned ER_LIT = 0;
  localparam int unsigned ER_W2  = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // opcode byte values (word bits 23:16)
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_NOP    = 8'h00;
  localparam logic [7:0] OPC_GOTO   = 8'h01;
  localparam logic [7:0] OPC_CALL   = 8'h02;
  localparam logic [7:0] OPC_MOVD   = 8'h03;
  localparam logic [7:0] OPC_BRA    = 8'h04;
  localparam logic [7:0] OPC_IND    = 8'h05;
  localparam logic [7:0] OPC_TBLRD  = 8'h06;
  localparam logic [7:0] OPC_TBLWR  = 8'h07;
  localparam logic [7:0] OPC_RET    = 8'h08;
  localparam logic [7:0] OPC_IRET   = 8'h09;
  localparam logic [7:0] OPC_SKIP   = 8'h0A;
  localparam logic [7:0] OPC_CBRA   = 8'h0B;

  // extra no-operation cycles and total cycle figures
  localparam logic [1:0] NOP_NONE   = 2'h0;
  localparam logic [1:0] NOP_ONE    = 2'h1;
  localparam logic [1:0] NOP_TWO    = 2'h2;
  localparam logic [1:0] CYC_ONE    = 2'h1;
  localparam logic [1:0] CYC_TWO    = 2'h2;
  localparam logic [1:0] CYC_THREE  = 2'h3;

  // size field codes
  localparam logic [1:0] SZ_WORD    = 2'h0;
  localparam logic [1:0] SZ_BYTE    = 2'h1;
  localparam logic [1:0] SZ_DOUBLE  = 2'h2;

  typedef enum logic [3:0] {
    CL_NOP, CL_GOTO_DW, CL_CALL_DW, CL_MOVD_DW, CL_BRANCH, CL_IND_JUMP,
    CL_TBL_RD, CL_TBL_WR, CL_RET, CL_IRET, CL_SKIP, CL_CBRANCH, CL_ALU
  } idt_class_e;

  function automatic idt_class_e idt_class_of(input logic [WORD_W-1:0] w);
    case (w[23:16])
      OPC_NOP:   return CL_NOP;
      OPC_GOTO:  return CL_GOTO_DW;
      OPC_CALL:  return CL_CALL_DW;
      OPC_MOVD:  return CL_MOVD_DW;
      OPC_BRA:   return CL_BRANCH;
      OPC_IND:   return CL_IND_JUMP;
      OPC_TBLRD: return CL_TBL_RD;
      OPC_TBLWR: return CL_TBL_WR;
      OPC_RET:   return CL_RET;
      OPC_IRET:  return CL_IRET;
      OPC_SKIP:  return CL_SKIP;
      OPC_CBRA:  return CL_CBRANCH;
      default:   return CL_ALU;
    endcase
  endfunction

  function automatic logic idt_is_double(input logic [WORD_W-1:0] w);
    idt_class_e c;
    c = idt_class_of(w);
    return (c == CL_GOTO_DW) || (c == CL_CALL_DW) || (c == CL_MOVD_DW);
  endfunction

endpackage

// >>> hdl/idt_nop_if.sv
// carrier between the decoder and its no-operation cycle timer
`timescale 1ns/1ps
`default_nettype none
interface idt_nop_if;
  logic       load;
  logic [1:0] count;
  logic       busy;
  modport ctl (output load, output count, input busy);
  modport tmr (input load, input count, output busy);
endinterface
`default_nettype wire

// >>> hdl/idt_nop_timer.sv
// counter of inserted no-operation cycles
`timescale 1ns/1ps
`default_nettype none
module idt_nop_timer (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  idt_nop_if.tmr    nop
);
  import idt_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (nop.load) begin
      cnt_next = nop.count;
    end else if (cnt_reg != NOP_NONE) begin
      cnt_next = cnt_reg - NOP_ONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= NOP_NONE;
    end else if (i_ce) begin
      cnt_reg <= cnt_next;
    end
  end

  assign nop.busy = (cnt_reg != NOP_NONE);
endmodule
`default_nettype wire

// >>> bench/idt_decoder_sva.sv
// assertion checker for the instruction decode and timing block
`timescale 1ns/1ps
`default_nettype none
module idt_decoder_sva (
  input wire logic                          i_clk,
  input wire logic                          i_rst,
  input wire logic                          i_ce,
  input wire logic                          i_fetch_valid,
  input wire logic                          o_fetch_ready,
  input wire logic                          i_cond_true,
  input wire logic [idt_pkg::FLAG_W-1:0]    i_flag_we,
  input wire logic [idt_pkg::FLAG_W-1:0]    i_flag_val,
  input wire logic                          o_op_valid,
  input wire idt_pkg::idt_class_e           o_op_class,
  input wire logic [idt_pkg::WORD_W-1:0]    o_op_word1,
  input wire logic [1:0]                    o_op_cycles,
  input wire logic                          o_literal_fault,
  input wire logic [15:0]                   o_signed_ten_bit_literal,
  input wire logic [1:0]                    o_op_size,
  input wire logic [idt_pkg::FLAG_W-1:0]    o_flags
);
  import idt_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // cycle counts and stalls
  // ----------------------------------------
  AST_DW_CYC: assert property (
    o_op_valid && o_op_class inside {CL_GOTO_DW, CL_CALL_DW, CL_MOVD_DW}
    |-> o_op_cycles == CYC_TWO) else $error("two-word op not two cycles");
  AST_TWO_NOP: assert property (
    o_op_valid && o_op_class inside {CL_BRANCH, CL_IND_JUMP, CL_TBL_RD, CL_TBL_WR}
    |-> o_op_cycles == CYC_TWO && !o_fetch_ready ##1 o_fetch_ready)
    else $error("flow change op wrong stall");
  AST_RET_NOP: assert property (
    o_op_valid && o_op_class inside {CL_RET, CL_IRET}
    |-> o_op_cycles == CYC_THREE && !o_fetch_ready ##1 !o_fetch_ready ##1 o_fetch_ready)
    else $error("return op wrong stall");
  AST_ONE_CYC: assert property (
    o_op_valid && o_op_class inside {CL_NOP, CL_ALU} |-> o_op_cycles == CYC_ONE)
    else $error("plain op not one cycle");
  AST_CBRA: assert property (
    o_op_valid && o_op_class == CL_CBRANCH
    |-> o_op_cycles == ($past(i_cond_true) ? CYC_TWO : CYC_ONE))
    else $error("conditional branch cycles wrong");
  AST_ISSUE: assert property (
    o_op_valid |-> $past(i_fetch_valid && o_fetch_ready && i_ce))
    else $error("issue without a fetch take");
  // ----------------------------------------
  // operand views and flags
  // ----------------------------------------
  AST_LIT: assert property (
    o_op_valid |-> o_literal_fault == (o_op_word1[0]
    && o_op_class inside {CL_GOTO_DW, CL_CALL_DW})) else $error("literal fault wrong");
  AST_SLIT: assert property (
    o_op_valid |-> o_signed_ten_bit_literal == {{6{o_op_word1[9]}}, o_op_word1[9:0]})
    else $error("signed literal not extended");
  AST_SIZE: assert property (
    o_op_valid |-> o_op_size == ((o_op_word1[15:14] == 2'h3) ? SZ_WORD : o_op_word1[15:14]))
    else $error("size modifier wrong");
  AST_FLAG_C: assert property (
    i_ce && i_flag_we[FL_C] |=> o_flags[FL_C] == $past(i_flag_val[FL_C]))
    else $error("carry flag not updated");
  AST_FLAG_Z: assert property (
    i_ce && i_flag_we[FL_Z] && !i_flag_val[FL_Z] |=> !o_flags[FL_Z])
    else $error("sticky zero not cleared");
  AST_FLAG_SB: assert property (
    i_ce && i_flag_we[FL_SB] |=> o_flags[FL_SB] == $past(i_flag_val[FL_SB]))
    else $error("saturation flag not updated");
endmodule
bind idt_decoder idt_decoder_sva u_sva (.*);
`default_nettype wire

// >>> bench/idt_fetch_model.sv
// program memory fetch path model offering queued words
`timescale 1ns/1ps
`default_nettype none
module idt_fetch_model (
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  input  wire logic  i_ready,
  input  wire logic  i_ce,
  output logic       o_valid,
  output logic [23:0] o_word,
  output logic       o_cond
);
  logic [24:0] q[$];
  initial o_valid = 1'b0;
  initial o_word = 24'h5A5A5A;
  initial o_cond = 1'b0;
  task automatic push(input logic [24:0] e);
    q.push_back(e);
  endtask
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
    end else begin
      if (o_valid && i_ready && i_ce) void'(q.pop_front());
      if (q.size() > 0) begin
        o_valid <= 1'b1;
        {o_cond, o_word} <= q[0];
      end else begin
        o_valid <= 1'b0;
        o_word <= ~o_word;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_instruction_decode_timing.sv
// self-checking bench for the instruction decode and timing block
`timescale 1ns/1ps
`default_nettype none
module tb_instruction_decode_timing;
  import idt_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_awvalid = 1'b0, i_wvalid = 1'b0;
  logic        i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, q;
  logic [3:0]  i_wstrb = 4'hF, o_bit_select_operand, o_base_work_register;
  logic [8:0]  i_flag_we = 9'h000, i_flag_val = 9'h000, o_flags;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_fetch_ready;
  logic        i_fetch_valid, i_cond_true, o_op_valid, o_nop_cycle, o_literal_fault;
  logic        o_acc_b_sel, o_accumulator_writeback_target, o_shadow_sel;
  logic [1:0]  o_bresp, o_rresp, o_op_cycles, o_op_size, r;
  logic [23:0] i_fetch_word, o_op_word1, o_op_word2;
  logic [22:0] o_wide_program_literal;
  logic [15:0] o_signed_ten_bit_literal;
  logic [12:0] o_file_addr;
  idt_class_e  o_op_class;
  logic [5:0]  exq[$], obq[$];
  logic [23:0] vw[3] = '{24'h0C0200, 24'h0C41FF, 24'h0CFFFF};
  logic [15:0] vs[3] = '{16'hFE00, 16'h01FF, 16'hFFFF};
  logic [1:0]  vz[3] = '{2'h0, 2'h1, 2'h0};
  int          err_total = 0, cmp_count = 0, nexp = 0, cyc = 0;

  idt_decoder uut (.*);
  idt_fetch_model fm (.i_clk(i_clk), .i_rst(i_rst), .i_ready(o_fetch_ready), .i_ce(i_ce),
    .o_valid(i_fetch_valid), .o_word(i_fetch_word), .o_cond(i_cond_true));

  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_op_valid === 1'b1) obq.push_back({o_op_class, o_op_cycles});
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // all sampling at the rising edge; a hang is ended by the cycle ceiling
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {i_awvalid, i_wvalid, i_arvalid, i_bready, i_rready} <= {w, w, !w, w, !w};
    i_awaddr <= a;
    i_araddr <= a;
    i_wdata <= d;
    do begin
      @(posedge i_clk);
      if (w ? o_awready : o_arready) {i_awvalid, i_arvalid} <= 2'b00;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!(w ? o_bvalid : o_rvalid));
    q = o_rdata;
    r = w ? o_bresp : o_rresp;
    {i_bready, i_rready} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    chk(r, RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    bus(1'b0, a, 32'h0);
    chk(q, e);
    chk(r, er);
  endtask
  task automatic flag(input logic [8:0] v, input logic [8:0] e);
    @(posedge i_clk);
    i_flag_we <= 9'h1FF;
    i_flag_val <= v;
    @(posedge i_clk);
    i_flag_we <= 9'h000;
    rd(REG_FLAGS, e, RESP_OKAY);
    chk(o_flags, e);
  endtask
  task automatic op(input logic [24:0] e, input idt_class_e c, input logic [1:0] n);
    fm.push(e);
    exq.push_back({c, n});
  endtask
  task automatic drain();
    while (fm.q.size() > 0) @(posedge i_clk);
    repeat (4) @(posedge i_clk);
  endtask
  task automatic ops_chk();
    chk(obq.size(), exq.size());
    foreach (exq[i]) begin
      chk(obq[i][5:2], exq[i][5:2]);
      if (exq[i][1:0] != 2'h0) chk(obq[i][1:0], exq[i][1:0]);
    end
    nexp += exq.size();
    exq.delete();
    obq.delete();
  endtask
  task automatic results();
    $display("errors=%0d compares=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    i_wstrb <= 4'h0;
    wr(REG_CTRL, 32'h0);
    i_wstrb <= 4'hF;
    rd(REG_CTRL, 32'h1, RESP_OKAY);
    rd(REG_ERR, 32'h0, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    rd(REG_FLAGS, 32'h0, RESP_OKAY);
    wr(REG_FLAGS, 32'h1FF);
    flag(9'h010, 9'h010);
    flag(9'h1EF, 9'h1EF);
    flag(9'h1FF, 9'h1EF);
    op(25'h00C1234, CL_ALU, CYC_ONE);
    for (int i = 4; i < 10; i++) op({1'b0, 8'(i), 16'h0}, idt_class_e'(i), (i > 7) ? CYC_THREE : CYC_TWO);
    op(25'h00B0000, CL_CBRANCH, CYC_ONE);
    op(25'h10B0000, CL_CBRANCH, CYC_TWO);
    op(25'h0000005, CL_NOP, CYC_ONE);
    op(25'h10A0000, CL_SKIP, 2'h0);
    fm.push(25'h00C0001);
    op(25'h00C0002, CL_ALU, CYC_ONE);
    op(25'h10A0000, CL_SKIP, 2'h0);
    fm.push(25'h0010004);
    fm.push(25'h0000000);
    op(25'h00C0003, CL_ALU, CYC_ONE);
    op(25'h00A0000, CL_SKIP, 2'h0);
    op(25'h00C0004, CL_ALU, CYC_ONE);
    op(25'h0030000, CL_MOVD_DW, CYC_TWO);
    fm.push(25'h0120000);
    op(25'h0020003, CL_CALL_DW, CYC_TWO);
    fm.push(25'h0000000);
    op(25'h0010002, CL_GOTO_DW, CYC_TWO);
    fm.push(25'h0000005);
    drain();
    ops_chk();
    chk(o_wide_program_literal, 23'h050002);
    rd(REG_ERR, 32'h3, RESP_OKAY);
    wr(REG_ERR, 32'h3);
    rd(REG_ERR, 32'h0, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      op({1'b0, vw[i]}, CL_ALU, CYC_ONE);
      drain();
      chk(o_signed_ten_bit_literal, vs[i]);
      chk(o_op_size, vz[i]);
    end
    ops_chk();
    chk({o_acc_b_sel, o_accumulator_writeback_target, o_shadow_sel, o_base_work_register,
      o_bit_select_operand, o_file_addr}, {3'h7, 8'hFF, 13'h1FFF});
    wr(REG_CTRL, 32'h0);
    op(25'h00C0005, CL_ALU, CYC_ONE);
    repeat (4) @(posedge i_clk);
    chk(obq.size(), 0);
    chk(o_fetch_ready, 1'b0);
    wr(REG_CTRL, 32'h1);
    drain();
    ops_chk();
    i_ce <= 1'b0;
    op(25'h00C0006, CL_ALU, CYC_ONE);
    repeat (4) @(posedge i_clk);
    chk(obq.size(), 0);
    i_ce <= 1'b1;
    drain();
    ops_chk();
    rd(REG_COUNT, 32'(nexp), RESP_OKAY);
    results();
  end
endmodule
`default_nettype wire
